// >>> include/pgia_dly_if.sv
// Interface between the aggregator and one power-ok rise-delay stage.
`timescale 1ns/10ps
`default_nettype none
interface pgia_dly_if;
  logic good;
  logic delayEn;
  logic asserted;
  modport agg (output good, output delayEn, input asserted);
  modport stage (input good, input delayEn, output asserted);
endinterface
`default_nettype wire

// >>> include/pgia_pkg.sv
// Package with register map, field positions, reset values and timing of the power-ok aggregator.
`default_nettype none
package pgia_pkg;

  // Monitored sources, one bit each in every per-source field.
  localparam int NSRC       = 6;
  localparam int SRC_BUCK0  = 0;
  localparam int SRC_BUCK1  = 1;
  localparam int SRC_STEPUP = 2;
  localparam int SRC_MONA   = 3;
  localparam int SRC_MONB   = 4;
  localparam int SRC_SUPPLY = 5;
  localparam int SEL_TWARN  = 6;

  // Register offsets.
  localparam logic [7:0] ADDR_TOP     = 8'h00;
  localparam logic [7:0] ADDR_FLAG_A  = 8'h02;
  localparam logic [7:0] ADDR_FLAG_B  = 8'h03;
  localparam logic [7:0] ADDR_RMASK   = 8'h04;
  localparam logic [7:0] ADDR_FMASK   = 8'h05;
  localparam logic [7:0] ADDR_MMASK   = 8'h06;
  localparam logic [7:0] ADDR_STATUS  = 8'h07;
  localparam logic [7:0] ADDR_MON_EN  = 8'h08;
  localparam logic [7:0] ADDR_SEL_A   = 8'h09;
  localparam logic [7:0] ADDR_SEL_B   = 8'h0A;
  localparam logic [7:0] ADDR_PG_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_PG_FLT  = 8'h0C;

  // Summary register fields (read only).
  localparam int TOP_BUCK   = 0;
  localparam int TOP_STEPUP = 1;
  localparam int TOP_DIAG   = 2;
  localparam int TOP_SYNC   = 3;
  localparam int TOP_MEAS   = 4;
  localparam int TOP_TWARN  = 5;
  localparam int TOP_RESET  = 6;

  // Second flag register and the single-mask register share these positions.
  localparam int FB_SYNC  = 0;
  localparam int FB_MEAS  = 1;
  localparam int FB_TWARN = 2;
  localparam int FB_RESET = 3;

  // Status register: live results beside the per-source bits.
  localparam int ST_SYNC  = 6;
  localparam int ST_TWARN = 7;

  // Monitor enable register: window type sits above the source enables.
  localparam int MON_WINDOW = 6;

  // Power-ok control register fields.
  localparam int CTL_POL_A = 0;
  localparam int CTL_POL_B = 1;
  localparam int CTL_OD_A  = 2;
  localparam int CTL_OD_B  = 3;
  localparam int CTL_DLY_A = 4;
  localparam int CTL_DLY_B = 5;

  // Reset values.
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_MON_EN  = 8'h3F;
  localparam logic [7:0] RST_SEL     = 8'h3F;
  localparam logic [7:0] RST_PG_CTRL = 8'h03;

  // Rise delay: 11 ms at a 25 MHz clock.
  localparam int CLK_KHZ       = 25000;
  localparam int RISE_DELAY_MS = 11;
  localparam int RISE_DELAY_CYC = RISE_DELAY_MS * CLK_KHZ;
  localparam int DLY_CNT_W     = 20;

  typedef enum logic [1:0] {
    PGIA_DLY_OFF  = 2'b00,
    PGIA_DLY_WAIT = 2'b01,
    PGIA_DLY_ON   = 2'b10
  } pgia_dly_state_t;

endpackage
`default_nettype wire

// >>> logic/pgia_aggregator.sv
// Power-ok and interrupt aggregator: monitor flags, masks, interrupt pin and two power-ok pins.
//
// Notes on behaviour
// - Buck window crossings set buck summary and per-buck flag; rise/fall masks; write one clears.
// - Step-up window crossings set its flag; own rise/fall masks, live status; write one clears.
// - First external monitor transitions set diagnostic summary and its flag; masked per direction.
// - Second external monitor transitions set diagnostic summary and its flag; masked per direction.
// - Main supply transitions set diagnostic summary and supply flag; masked per direction.
// - Sync clock appearing, vanishing or absent while detection runs sets the clock flag.
// - Finished load measurement sets a maskable flag with no status bit; write one clears.
// - Interrupt pin and both power-ok outputs have independent source selections.
// - A disabled converter's monitor is ignored: no interrupt, no power-ok deassertion.
// - One window bit: zero checks undervoltage only, one checks both limits.
// - All rail and thermal-warning flags are ORed to the pin, each behind its mask.
// - Two selection registers choose which enabled monitors feed each power-ok output.
// - Polarity and push-pull or open-drain drive are set per power-ok output.
// - Power-ok asserts only while every selected monitor is in tolerance.
// - With rise delay set, power-ok asserts 11 ms after all monitors settle.
// - Thermal shutdown or supply overvoltage forces both power-ok outputs inactive.
// - Gated or continuous power-ok mode is chosen by a factory setting.
// - Interrupt pin is low while any flag is set, except a masked register-reset flag; released when all are clear.
// - Every start-up sets the register-reset flag; maskable; write one clears.
`timescale 1ns/10ps
`default_nettype none
module pgia_aggregator
  import pgia_pkg::*;
#(
  parameter int unsigned DELAY_CYC       = RISE_DELAY_CYC,
  parameter bit          CONTINUOUS_MODE = 1'b1
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rst_n,
  // Register port
  input  wire logic [7:0]      regAddr,
  input  wire logic [7:0]      regWrData,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  output logic      [7:0]      regRdData,
  // Comparator results per source, one means within that limit
  input  wire logic [NSRC-1:0] underOk,
  input  wire logic [NSRC-1:0] overOk,
  // Converter enables
  input  wire logic [1:0]      buckEnabled,
  input  wire logic            stepUpEnabled,
  // Other events
  input  wire logic            syncClkPresent,
  input  wire logic            clkDetectEn,
  input  wire logic            loadMeasDone,
  input  wire logic            tempWarn,
  input  wire logic            thermShutdown,
  input  wire logic            supplyOvp,
  // Pins
  output logic                 irq_n_pin,
  output logic                 power_ok_out_a,
  output logic                 power_ok_out_a_oe_n,
  output logic                 power_ok_out_b,
  output logic                 power_ok_out_b_oe_n
);

  logic [7:0]      riseMask_ff;
  logic [7:0]      fallMask_ff;
  logic [7:0]      miscMask_ff;
  logic [7:0]      monEn_ff;
  logic [7:0]      selA_ff;
  logic [7:0]      selB_ff;
  logic [7:0]      pgCtrl_ff;
  logic [NSRC-1:0] monFlag_ff;
  logic [NSRC-1:0] prevOk_ff;
  logic            syncFlag_ff;
  logic            measFlag_ff;
  logic            warnFlag_ff;
  logic            resetFlag_ff;
  logic            syncPrev_ff;
  logic [1:0]      pgFault_ff;
  logic [1:0]      pgOut_ff;
  logic [1:0]      pgOeN_ff;
  logic            irqN_ff;
  logic [7:0]      rdData_ff;
  logic [7:0]      nxt_rdData;
  logic [NSRC-1:0] srcOk;
  logic [NSRC-1:0] srcActive;
  logic [NSRC-1:0] riseEvt;
  logic [NSRC-1:0] fallEvt;
  logic [NSRC-1:0] srcSet;
  logic            syncEvt;
  logic            wrFlagA;
  logic            wrFlagB;
  logic            wrPgFlt;
  logic            anyFlag;
  logic            forceOff;
  logic [1:0]      allOk;
  logic [1:0]      pgAsserted;
  logic [1:0]      pgLevel;
  logic [7:0]      topFlags;
  logic [7:0]      pgSel [2];

  pgia_dly_if dly [2] ();

  assign wrFlagA = regWrite && (regAddr == ADDR_FLAG_A);
  assign wrFlagB = regWrite && (regAddr == ADDR_FLAG_B);
  assign wrPgFlt = regWrite && (regAddr == ADDR_PG_FLT);

  // Configuration registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      riseMask_ff <= RST_MASK;
      fallMask_ff <= RST_MASK;
      miscMask_ff <= RST_MASK;
      monEn_ff    <= RST_MON_EN;
      selA_ff     <= RST_SEL;
      selB_ff     <= RST_SEL;
      pgCtrl_ff   <= RST_PG_CTRL;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_RMASK:   riseMask_ff <= regWrData;
        ADDR_FMASK:   fallMask_ff <= regWrData;
        ADDR_MMASK:   miscMask_ff <= regWrData;
        ADDR_MON_EN:  monEn_ff    <= regWrData;
        ADDR_SEL_A:   selA_ff     <= regWrData;
        ADDR_SEL_B:   selB_ff     <= regWrData;
        ADDR_PG_CTRL: pgCtrl_ff   <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // A window check of zero ignores the overvoltage comparator entirely.
  assign srcOk = underOk & (overOk | {NSRC{~monEn_ff[MON_WINDOW]}});

  // Converter monitors follow their converter's enable so a disabled converter never trips anything.
  assign srcActive = monEn_ff[NSRC-1:0] &
                     {3'b111, stepUpEnabled, buckEnabled};

  assign riseEvt = srcActive & srcOk & ~prevOk_ff;
  assign fallEvt = srcActive & ~srcOk & prevOk_ff;
  assign srcSet  = (riseEvt & ~riseMask_ff[NSRC-1:0]) |
                   (fallEvt & ~fallMask_ff[NSRC-1:0]);

  // An inactive monitor is remembered as good, so its first look after enabling counts.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prevOk_ff <= '1;
    end else begin
      prevOk_ff <= (srcOk & srcActive) | ~srcActive;
    end
  end

  // Per-source sticky flags: a new event wins over a clear in the same cycle.
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_flag
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          monFlag_ff[i] <= 1'b0;
        end else if (srcSet[i]) begin
          monFlag_ff[i] <= 1'b1;
        end else if (wrFlagA && regWrData[i]) begin
          monFlag_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign syncEvt = clkDetectEn && ((syncClkPresent ^ syncPrev_ff) || !syncClkPresent);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncPrev_ff <= 1'b1;
    end else begin
      syncPrev_ff <= syncClkPresent;
    end
  end

  // Single-mask flags; the warning flag keeps setting while the warning lasts.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncFlag_ff <= 1'b0;
    end else if (syncEvt && !miscMask_ff[FB_SYNC]) begin
      syncFlag_ff <= 1'b1;
    end else if (wrFlagB && regWrData[FB_SYNC]) begin
      syncFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      measFlag_ff <= 1'b0;
    end else if (loadMeasDone && !miscMask_ff[FB_MEAS]) begin
      measFlag_ff <= 1'b1;
    end else if (wrFlagB && regWrData[FB_MEAS]) begin
      measFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      warnFlag_ff <= 1'b0;
    end else if (tempWarn && !miscMask_ff[FB_TWARN]) begin
      warnFlag_ff <= 1'b1;
    end else if (wrFlagB && regWrData[FB_TWARN]) begin
      warnFlag_ff <= 1'b0;
    end
  end

  // Reset is the start-up event, so the flag comes out of reset already set.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetFlag_ff <= 1'b1;
    end else if (wrFlagB && regWrData[FB_RESET]) begin
      resetFlag_ff <= 1'b0;
    end
  end

  // Masks act where flags are set, except the register-reset flag, whose mask gates it here at the pin.
  assign anyFlag = (|monFlag_ff) | syncFlag_ff | measFlag_ff | warnFlag_ff |
                   (resetFlag_ff & ~miscMask_ff[FB_RESET]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqN_ff <= 1'b1;
    end else begin
      irqN_ff <= ~anyFlag;
    end
  end

  assign forceOff = thermShutdown || supplyOvp;
  assign pgSel[0] = selA_ff;
  assign pgSel[1] = selB_ff;

  // Power-ok paths, one per output, with their own selection and delay stage.
  generate
    for (genvar k = 0; k < 2; k++) begin : g_pg
      assign allOk[k] = (&(srcOk | ~srcActive | ~pgSel[k][NSRC-1:0])) &&
                        !(tempWarn && pgSel[k][SEL_TWARN]);
      assign dly[k].good    = allOk[k] && !forceOff;
      assign dly[k].delayEn = pgCtrl_ff[CTL_DLY_A + k];

      pgia_rise_delay #(
        .DELAY_CYC (DELAY_CYC)
      ) u_delay (
        .clock (clock),
        .rst_n (rst_n),
        .dly   (dly[k])
      );

      // Gated mode holds a seen fault until software clears it.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pgFault_ff[k] <= 1'b0;
        end else if (!allOk[k]) begin
          pgFault_ff[k] <= 1'b1;
        end else if (wrPgFlt && regWrData[k]) begin
          pgFault_ff[k] <= 1'b0;
        end
      end

      assign pgAsserted[k] = dly[k].asserted && !forceOff &&
                             (CONTINUOUS_MODE || !pgFault_ff[k]);
      assign pgLevel[k] = pgCtrl_ff[CTL_POL_A + k] ? pgAsserted[k] : !pgAsserted[k];

      // Open drain only pulls low and lets the line float for a high level.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pgOut_ff[k] <= 1'b0;
          pgOeN_ff[k] <= 1'b0;
        end else begin
          pgOut_ff[k] <= pgLevel[k];
          pgOeN_ff[k] <= pgCtrl_ff[CTL_OD_A + k] && pgLevel[k];
        end
      end
    end
  endgenerate

  assign topFlags = {1'b0, resetFlag_ff, warnFlag_ff, measFlag_ff, syncFlag_ff,
                     |monFlag_ff[SRC_SUPPLY:SRC_MONA], monFlag_ff[SRC_STEPUP],
                     |monFlag_ff[SRC_BUCK1:SRC_BUCK0]};

  always_comb begin
    nxt_rdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        ADDR_TOP:     nxt_rdData = topFlags;
        ADDR_FLAG_A:  nxt_rdData = {2'b00, monFlag_ff};
        ADDR_FLAG_B:  nxt_rdData = {4'h0, resetFlag_ff, warnFlag_ff, measFlag_ff, syncFlag_ff};
        ADDR_RMASK:   nxt_rdData = riseMask_ff;
        ADDR_FMASK:   nxt_rdData = fallMask_ff;
        ADDR_MMASK:   nxt_rdData = miscMask_ff;
        ADDR_STATUS:  nxt_rdData = {tempWarn, syncClkPresent, srcOk};
        ADDR_MON_EN:  nxt_rdData = monEn_ff;
        ADDR_SEL_A:   nxt_rdData = selA_ff;
        ADDR_SEL_B:   nxt_rdData = selB_ff;
        ADDR_PG_CTRL: nxt_rdData = pgCtrl_ff;
        ADDR_PG_FLT:  nxt_rdData = {6'h00, pgFault_ff};
        default:      nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData           = rdData_ff;
  assign irq_n_pin           = irqN_ff;
  assign power_ok_out_a      = pgOut_ff[0];
  assign power_ok_out_b      = pgOut_ff[1];
  assign power_ok_out_a_oe_n = pgOeN_ff[0];
  assign power_ok_out_b_oe_n = pgOeN_ff[1];

  buck_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
    (srcActive[0] && srcOk[0] && !prevOk_ff[0] && !riseMask_ff[0]) |=> monFlag_ff[0])
    else $error("Unmasked buck rise did not set its flag.");

  stepup_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
    (srcActive[2] && !srcOk[2] && prevOk_ff[2] && fallMask_ff[2] && !monFlag_ff[2])
    |=> !monFlag_ff[2])
    else $error("Masked step-up fall set its flag.");

  diag_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
    (srcActive[3] && !srcOk[3] && prevOk_ff[3] && !fallMask_ff[3])
    |=> ##1 (monFlag_ff[3] || $past(wrFlagA)) ##0 !irq_n_pin)
    else $error("Monitor fall did not reach flag and pin.");

  off_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!buckEnabled[1] && !monFlag_ff[1]) |=> !monFlag_ff[1])
    else $error("Disabled buck raised a flag.");

  window_uv_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!monEn_ff[MON_WINDOW] && underOk == '1 && selA_ff == 8'h3F && !forceOff
     && !pgCtrl_ff[CTL_DLY_A] && !tempWarn && CONTINUOUS_MODE) [*3]
    |=> pgOut_ff[0] == pgCtrl_ff[CTL_POL_A])
    else $error("Overvoltage result used with window check off.");

  irq_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    ((|monFlag_ff) || syncFlag_ff || measFlag_ff || warnFlag_ff) |=> !irq_n_pin)
    else $error("Interrupt pin high with a flag pending.");

  irq_free_a: assert property (@(posedge clock) disable iff (!rst_n)
    (monFlag_ff == '0 && !syncFlag_ff && !measFlag_ff && !warnFlag_ff
     && (!resetFlag_ff || miscMask_ff[FB_RESET])) |=> irq_n_pin)
    else $error("Interrupt pin low with no flag pending.");

  reset_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrFlagB && regWrData[FB_RESET]) |=> !resetFlag_ff)
    else $error("Register-reset flag not cleared by write one.");

  force_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    (forceOff && pgCtrl_ff[CTL_POL_B]) |=> !pgOut_ff[1])
    else $error("Power-ok not forced inactive on shutdown.");

  push_pull_a: assert property (@(posedge clock) disable iff (!rst_n)
    !pgCtrl_ff[CTL_OD_A] |=> !power_ok_out_a_oe_n)
    else $error("Push-pull power-ok not driven.");

  pg_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!allOk[0] && pgCtrl_ff[CTL_POL_A]) |=> !pgOut_ff[0])
    else $error("Power-ok active with a selected monitor out of tolerance.");

endmodule
`default_nettype wire

// >>> logic/pgia_rise_delay.sv
// Rise-delay stage that holds a power-ok indication back after its inputs settle.
`timescale 1ns/10ps
`default_nettype none
module pgia_rise_delay
  import pgia_pkg::*;
#(
  parameter int unsigned DELAY_CYC = RISE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Link to the aggregator
  pgia_dly_if.stage dly
);

  pgia_dly_state_t        state_ff;
  logic [DLY_CNT_W-1:0]   count_ff;

  // Losing the good condition drops the indication at once; only rising is delayed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PGIA_DLY_OFF;
      count_ff <= '0;
    end else begin
      case (state_ff)
        PGIA_DLY_OFF: begin
          count_ff <= '0;
          if (dly.good && !dly.delayEn) begin
            state_ff <= PGIA_DLY_ON;
          end else if (dly.good) begin
            state_ff <= PGIA_DLY_WAIT;
          end
        end
        PGIA_DLY_WAIT: begin
          if (!dly.good) begin
            state_ff <= PGIA_DLY_OFF;
          end else if (!dly.delayEn || count_ff == DLY_CNT_W'(DELAY_CYC - 2)) begin
            state_ff <= PGIA_DLY_ON;
          end else begin
            count_ff <= count_ff + 1'b1;
          end
        end
        PGIA_DLY_ON: begin
          if (!dly.good) begin
            state_ff <= PGIA_DLY_OFF;
          end
        end
        default: begin
          state_ff <= PGIA_DLY_OFF;
        end
      endcase
    end
  end

  assign dly.asserted = (state_ff == PGIA_DLY_ON) && dly.good;

  wait_holds_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == PGIA_DLY_OFF && dly.good && dly.delayEn) |=> !dly.asserted [*2])
    else $error("Power-ok rose without the rise delay.");

endmodule
`default_nettype wire

// >>> tb/pgia_host_model.sv
// Host-side model: resolves the power-ok wires and notes interrupt requests.
`timescale 1ns/10ps
`default_nettype none
module pgia_host_model (
  // Pins from the device
  input  wire logic irq_n_pin,
  input  wire logic outA,
  input  wire logic oeNA,
  input  wire logic outB,
  input  wire logic oeNB,
  // Levels seen on the board
  output logic      wireA,
  output logic      wireB,
  output var int    irqCount
);
  // A released line is pulled up on the board, so it never floats.
  assign wireA = oeNA ? 1'b1 : outA;
  assign wireB = oeNB ? 1'b1 : outB;
  initial irqCount = 0;
  // Each falling edge is counted as one interrupt request.
  always @(negedge irq_n_pin) irqCount++;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the power-ok and interrupt aggregator.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pgia_pkg::*;
  localparam int DCYC = 20;
  logic            clock = 1'b0;
  logic            rst_n = 1'b0;
  logic [7:0]      regAddr = 8'h00;
  logic [7:0]      regWrData = 8'h00;
  logic            regWrite = 1'b0;
  logic            regRead = 1'b0;
  logic [7:0]      regRdData;
  logic [NSRC-1:0] underOk = 6'h3F;
  logic [NSRC-1:0] overOk = 6'h3F;
  logic [1:0]      buckEnabled = 2'h3;
  logic            stepUpEnabled = 1'b1;
  logic            syncClkPresent = 1'b1;
  logic            clkDetectEn = 1'b0;
  logic            loadMeasDone = 1'b0;
  logic            tempWarn = 1'b0;
  logic            thermShutdown = 1'b0;
  logic            supplyOvp = 1'b0;
  logic            irq_n_pin, pokA, pokB, oeNA, oeNB, wireA, wireB;
  int              irqCount;
  int              mismatches = 0;
  int              totalChecks = 0;

  always #20 clock = ~clock;

  pgia_aggregator #(.DELAY_CYC(DCYC)) pgia_aggregator_inst (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .underOk(underOk), .overOk(overOk), .buckEnabled(buckEnabled),
    .stepUpEnabled(stepUpEnabled), .syncClkPresent(syncClkPresent),
    .clkDetectEn(clkDetectEn), .loadMeasDone(loadMeasDone), .tempWarn(tempWarn),
    .thermShutdown(thermShutdown), .supplyOvp(supplyOvp), .irq_n_pin(irq_n_pin),
    .power_ok_out_a(pokA), .power_ok_out_a_oe_n(oeNA),
    .power_ok_out_b(pokB), .power_ok_out_b_oe_n(oeNB));

  pgia_host_model pgia_host_model_inst (
    .irq_n_pin(irq_n_pin), .outA(pokA), .oeNA(oeNA), .outB(pokB), .oeNB(oeNB),
    .wireA(wireA), .wireB(wireB), .irqCount(irqCount));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic pin(input logic got, input logic exp, input string msg);
    chk({7'h00, got}, {7'h00, exp}, msg);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdData, exp, msg);
  endtask

  task automatic t_reset();
    rchk(ADDR_MON_EN, RST_MON_EN, "mon en");
    rchk(ADDR_SEL_A, RST_SEL, "sel a");
    rchk(ADDR_SEL_B, RST_SEL, "sel b");
    rchk(ADDR_PG_CTRL, RST_PG_CTRL, "pg ctrl");
    rchk(ADDR_FMASK, RST_MASK, "fall mask");
    rchk(ADDR_FLAG_B, 8'h01 << FB_RESET, "start flag");
    pin(irq_n_pin, 1'b0, "irq at start");
    rchk(8'h40, 8'h00, "unmapped");
    wr(ADDR_FLAG_B, 8'hFF);
    wt(3);
    pin(irq_n_pin, 1'b1, "irq released");
    pin(pokA, 1'b1, "pok a good");
    $display("test reset done");
  endtask

  task automatic t_sources();
    logic [7:0] top;
    for (int s = 0; s < NSRC; s++) begin
      top = 8'h01 << ((s < 2) ? TOP_BUCK : (s == SRC_STEPUP) ? TOP_STEPUP : TOP_DIAG);
      @(posedge clock);
      underOk[s] <= 1'b0;
      wt(4);
      rchk(ADDR_FLAG_A, 8'h01 << s, "fall flag");
      rchk(ADDR_TOP, top, "summary");
      rchk(ADDR_STATUS, 8'h7F ^ (8'h01 << s), "live");
      pin(irq_n_pin, 1'b0, "irq low");
      pin(pokA, 1'b0, "pok drop");
      rchk(ADDR_PG_FLT, 8'h03, "fault latch");
      wr(ADDR_FLAG_A, 8'h01 << s);
      wt(3);
      rchk(ADDR_FLAG_A, 8'h00, "cleared");
      pin(irq_n_pin, 1'b1, "irq high");
      @(posedge clock);
      underOk[s] <= 1'b1;
      wt(4);
      rchk(ADDR_FLAG_A, 8'h01 << s, "rise flag");
      wr(ADDR_FLAG_A, 8'h01 << s);
    end
    wr(ADDR_PG_FLT, 8'h03);
    rchk(ADDR_PG_FLT, 8'h00, "fault clear");
    wr(ADDR_FMASK, 8'h3F);
    wr(ADDR_RMASK, 8'h3F);
    underOk[3:2] <= 2'b00;
    wt(4);
    underOk[3:2] <= 2'b11;
    wt(4);
    rchk(ADDR_FLAG_A, 8'h00, "masked");
    pin(irq_n_pin, 1'b1, "irq masked");
    wr(ADDR_FMASK, 8'h00);
    wr(ADDR_RMASK, 8'h00);
    $display("test sources done");
  endtask

  task automatic t_window();
    @(posedge clock);
    overOk[SRC_STEPUP] <= 1'b0;
    wt(4);
    rchk(ADDR_FLAG_A, 8'h00, "uv only");
    pin(pokA, 1'b1, "pok uv only");
    wr(ADDR_MON_EN, 8'h7F);
    wt(4);
    rchk(ADDR_FLAG_A, 8'h04, "uv and ov");
    pin(pokA, 1'b0, "pok ov");
    overOk[SRC_STEPUP] <= 1'b1;
    wt(3);
    wr(ADDR_MON_EN, 8'h3F);
    wr(ADDR_FLAG_A, 8'hFF);
    $display("test window done");
  endtask

  task automatic t_disable();
    @(posedge clock);
    buckEnabled[1] <= 1'b0;
    wt(4);
    wr(ADDR_FLAG_A, 8'hFF);
    underOk[1] <= 1'b0;
    wt(4);
    rchk(ADDR_FLAG_A, 8'h00, "off no flag");
    pin(irq_n_pin, 1'b1, "off no irq");
    pin(pokA, 1'b1, "off pok kept");
    underOk[1] <= 1'b1;
    buckEnabled[1] <= 1'b1;
    wt(4);
    wr(ADDR_FLAG_A, 8'hFF);
    $display("test disable done");
  endtask

  task automatic t_select();
    wr(ADDR_SEL_A, 8'h01);
    wr(ADDR_SEL_B, 8'h02);
    underOk[1] <= 1'b0;
    wt(3);
    pin(pokA, 1'b1, "sel a ignores");
    pin(pokB, 1'b0, "sel b follows");
    wr(ADDR_PG_CTRL, 8'h01);
    wt(3);
    pin(pokB, 1'b1, "pol b low");
    wr(ADDR_PG_CTRL, 8'h0F);
    wt(3);
    pin(oeNA, 1'b1, "od a released");
    pin(wireA, 1'b1, "wire a up");
    pin(oeNB, 1'b0, "od b drives");
    pin(wireB, 1'b0, "wire b low");
    underOk[1] <= 1'b1;
    wr(ADDR_PG_CTRL, RST_PG_CTRL);
    wr(ADDR_SEL_A, RST_SEL);
    wr(ADDR_SEL_B, RST_SEL);
    wr(ADDR_FLAG_A, 8'hFF);
    $display("test select done");
  endtask

  task automatic t_force();
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      thermShutdown <= (i == 0);
      supplyOvp <= (i == 1);
      wt(2);
      pin(pokA, 1'b0, "force a");
      pin(pokB, 1'b0, "force b");
      thermShutdown <= 1'b0;
      supplyOvp <= 1'b0;
      wt(3);
      pin(pokA, 1'b1, "force end");
    end
    $display("test force done");
  endtask

  task automatic t_delay();
    wr(ADDR_PG_CTRL, 8'h13);
    underOk[0] <= 1'b0;
    wt(3);
    pin(pokA, 1'b0, "delay drop");
    underOk[0] <= 1'b1;
    wt(3);
    pin(pokB, 1'b1, "b undelayed");
    wt(DCYC - 3);
    pin(pokA, 1'b0, "still held");
    wt(1);
    pin(pokA, 1'b1, "delayed rise");
    wr(ADDR_PG_CTRL, RST_PG_CTRL);
    wr(ADDR_FLAG_A, 8'hFF);
    $display("test delay done");
  endtask

  task automatic t_events();
    int n;
    n = irqCount;
    clkDetectEn <= 1'b1;
    wt(3);
    rchk(ADDR_FLAG_B, 8'h00, "clock steady");
    syncClkPresent <= 1'b0;
    wt(3);
    rchk(ADDR_STATUS, 8'h3F, "clock live");
    rchk(ADDR_FLAG_B, 8'h01, "clock lost");
    clkDetectEn <= 1'b0;
    syncClkPresent <= 1'b1;
    wr(ADDR_FLAG_B, 8'hFF);
    loadMeasDone <= 1'b1;
    @(posedge clock);
    loadMeasDone <= 1'b0;
    wt(3);
    rchk(ADDR_FLAG_B, 8'h02, "meas");
    wr(ADDR_FLAG_B, 8'hFF);
    wr(ADDR_MMASK, 8'h02);
    loadMeasDone <= 1'b1;
    @(posedge clock);
    loadMeasDone <= 1'b0;
    wt(3);
    rchk(ADDR_FLAG_B, 8'h00, "meas masked");
    pin(irq_n_pin, 1'b1, "meas no irq");
    wr(ADDR_MMASK, 8'h00);
    tempWarn <= 1'b1;
    @(posedge clock);
    tempWarn <= 1'b0;
    wt(3);
    rchk(ADDR_TOP, 8'h01 << TOP_TWARN, "twarn");
    pin(irq_n_pin, 1'b0, "twarn irq");
    wr(ADDR_FLAG_B, 8'hFF);
    pin(irqCount > n, 1'b1, "host saw irq");
    @(posedge clock);
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    rchk(ADDR_FLAG_B, 8'h01 << FB_RESET, "restart flag");
    pin(irq_n_pin, 1'b0, "irq restart");
    $display("test events done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_sources();
    t_window();
    t_disable();
    t_select();
    t_force();
    t_delay();
    t_events();
    print_verdict();
  end

  // The tests need a few hundred cycles; a hang is cut short well beyond that.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
